// ===== hw/dac_input_pkg.sv
// Shared constants for the serial converter input logic
package dac_input_pkg;
    localparam int          WORD_BITS    = 16;           // Converter code width
    localparam int          FIFO_DEPTH   = 16;           // Words buffered ahead of the code register
    localparam int          CNT_BITS     = 9;            // Link clock counter width within a frame
    localparam int          CELL_CLKS    = 16;           // Link clocks per asynchronous bit cell
    localparam int          FIRST_SAMPLE = 24;           // Link clock that samples the top data bit
    localparam logic [8:0]  CNT_FIRST    = 9'h001;       // Count on the edge that sees the start bit low
    localparam logic [8:0]  START_CHECK  = 9'h008;       // Middle of the start cell
    localparam logic [8:0]  MSB_SAMPLE   = 9'h018;       // 24: top data bit
    localparam logic [8:0]  STOP_SAMPLE  = 9'h118;       // 24 + 16*16: stop bit
    localparam logic [3:0]  SAMPLE_PHASE = 4'h8;         // Low nibble of every sampling count
    localparam logic [15:0] CODE_MIN     = 16'h0000;     // Code for the bottom of any span
    localparam logic [1:0]  SPAN_V_0_5   = 2'h0;         // 0 V to 5 V
    localparam logic [1:0]  SPAN_I_4_20  = 2'h1;         // 4 mA to 20 mA
    localparam logic [1:0]  SPAN_I_0_20  = 2'h2;         // 0 mA to 20 mA
    localparam logic [1:0]  SPAN_I_0_24  = 2'h3;         // 0 mA to 24 mA
    typedef enum logic [2:0] {
        RX_IDLE = 3'h1,
        RX_RECV = 3'h2,
        RX_PUSH = 3'h4
    } rx_state_t;
endpackage

// ===== hw/word_stream_if.sv
// Valid/ready word stream between the receiver, buffer and code register
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int WIDTH = 16);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== hw/word_fifo.sv
// Word buffer with registered read data and honest full/empty
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic   clk,
    input  wire logic   rst_b,
    word_stream_if.snk  in_s,
    word_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
        logic [WIDTH-1:0]            q;
        logic                        qv;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic        full;
    logic        empty;

    // Occupancy of the memory, output register not counted
    assign empty = (s.wr == s.rd);
    assign full  = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);

    assign in_s.ready  = ~full;
    assign out_s.valid = s.qv;
    assign out_s.data  = s.q;

    // Write on accepted push, prefetch head into output register
    always_comb
    begin
        next_s = s;
        if (in_s.valid && !full)
        begin
            next_s.mem[s.wr[AW-1:0]] = in_s.data;
            next_s.wr                = s.wr + (AW + 1)'(1);
        end
        if (s.qv && out_s.ready)
            next_s.qv = 1'b0;
        if (!empty && (!s.qv || out_s.ready))
        begin
            next_s.q  = s.mem[s.rd[AW-1:0]];
            next_s.qv = 1'b1;
            next_s.rd = s.rd + (AW + 1)'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end
endmodule
`default_nettype wire

// ===== hw/serial_dac_loop_input_control.sv
// Serial input control of a 16-bit loop output converter
// What this block does
// - While clear is high the code is held at the bottom of the span whatever the span pins say.
// - An asynchronous word is framed by a start bit of 0 and a stop bit of 1.
// - Asynchronous data is sampled on the link clock rise at the middle of each bit cell.
// - Each cell is 16 link clocks and the start cell begins at the first clock after the data fall.
// - The top data bit is sampled at link clock 24, the next at 40, each later one 16 clocks on.
// - A good stop bit hands the received word on so the code updates.
// - A stop bit sampled low gives a one link clock high pulse on the serial output right after.
// - A framing error leaves the previous code in place.
// - After clear falls the code stays at the span bottom and the input shift register is untouched.
// - In three-wire mode a latch rise loads the shift register into the code.
// - In three-wire mode the serial output passes shifted data on for daisy chaining.
// - After reset the code sits at the bottom of the selected span.
`timescale 1ns/1ps
`default_nettype none
module serial_dac_loop_input_control #(
    parameter int WIDTH = dac_input_pkg::WORD_BITS,
    parameter int DEPTH = dac_input_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             link_clk,
    input  wire logic             data_in,
    input  wire logic             latch,
    input  wire logic             clear,
    input  wire logic [1:0]       range_sel,
    input  wire logic             async_mode,
    output logic                  data_out,
    output logic [WIDTH-1:0]      dac_code,
    output logic [1:0]            span
);
    typedef struct packed {
        logic [2:0]                   link_sync;
        logic [2:0]                   latch_sync;
        logic [1:0]                   data_sync;
        logic [1:0]                   clr_sync;
        logic [1:0]                   mode_sync;
        logic [1:0][1:0]              rng_sync;
        dac_input_pkg::rx_state_t     st;
        logic [dac_input_pkg::CNT_BITS-1:0] cnt;
        logic [WIDTH-1:0]             shreg;
        logic [WIDTH-1:0]             word;
        logic                         push_pend;
        logic                         dout;
        logic [WIDTH-1:0]             code;
        logic [1:0]                   span;
    } ctl_state_t;

    ctl_state_t s;
    ctl_state_t next_s;
    logic       link_rise;
    logic       latch_rise;
    logic       din;
    logic       clr;
    logic       amode;

    word_stream_if #(.WIDTH(WIDTH)) rx_s ();
    word_stream_if #(.WIDTH(WIDTH)) code_s ();

    // Buffer between receiver and code register
    word_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_b (rst_b),
        .in_s  (rx_s.snk),
        .out_s (code_s.src)
    );

    // Edges and levels from second and third sync stages only
    assign link_rise  = s.link_sync[1] & ~s.link_sync[2];
    assign latch_rise = s.latch_sync[1] & ~s.latch_sync[2];
    assign din        = s.data_sync[1];
    assign clr        = s.clr_sync[1];
    assign amode      = s.mode_sync[1];

    assign rx_s.valid   = s.push_pend;
    assign rx_s.data    = s.word;
    assign code_s.ready = 1'b1;      // Words reaching the head during clear are dropped
    assign data_out     = s.dout;
    assign dac_code     = s.code;
    assign span         = s.span;

    // Receiver, shifter, latch and code update
    always_comb
    begin
        next_s            = s;
        next_s.link_sync  = {s.link_sync[1:0], link_clk};
        next_s.latch_sync = {s.latch_sync[1:0], latch};
        next_s.data_sync  = {s.data_sync[0], data_in};
        next_s.clr_sync   = {s.clr_sync[0], clear};
        next_s.mode_sync  = {s.mode_sync[0], async_mode};
        next_s.rng_sync   = {s.rng_sync[0], range_sel};
        next_s.span       = s.rng_sync[1];
        if (s.push_pend && rx_s.ready)
            next_s.push_pend = 1'b0;
        if (amode)
        begin
            if (link_rise && s.st != dac_input_pkg::RX_RECV)
                next_s.dout = 1'b0;
            unique case (s.st)
                dac_input_pkg::RX_IDLE:
                begin
                    if (link_rise && !din)
                    begin
                        next_s.st  = dac_input_pkg::RX_RECV;
                        next_s.cnt = dac_input_pkg::CNT_FIRST;
                    end
                end
                dac_input_pkg::RX_RECV:
                begin
                    if (link_rise)
                    begin
                        next_s.cnt = s.cnt + dac_input_pkg::CNT_BITS'(1);
                        if (s.cnt == dac_input_pkg::START_CHECK)
                        begin
                            if (din)
                                next_s.st = dac_input_pkg::RX_IDLE;
                        end
                        else if (s.cnt == dac_input_pkg::STOP_SAMPLE)
                        begin
                            if (din)
                            begin
                                next_s.word = s.shreg;
                                next_s.st   = dac_input_pkg::RX_PUSH;
                            end
                            else
                            begin
                                next_s.dout = 1'b1;
                                next_s.st   = dac_input_pkg::RX_IDLE;
                            end
                        end
                        else if (s.cnt[3:0] == dac_input_pkg::SAMPLE_PHASE)
                            next_s.shreg = {s.shreg[WIDTH-2:0], din};
                    end
                end
                dac_input_pkg::RX_PUSH:
                begin
                    // Wait for the previous word to be taken
                    if (!s.push_pend)
                    begin
                        next_s.push_pend = 1'b1;
                        next_s.st        = dac_input_pkg::RX_IDLE;
                    end
                end
            endcase
        end
        else
        begin
            next_s.st = dac_input_pkg::RX_IDLE;
            if (link_rise)
            begin
                next_s.shreg = {s.shreg[WIDTH-2:0], din};
                next_s.dout  = s.shreg[WIDTH-1];
            end
            if (latch_rise && !s.push_pend)
            begin
                next_s.word      = s.shreg;
                next_s.push_pend = 1'b1;
            end
        end
        // Clear wins; shift register left alone
        if (clr)
            next_s.code = dac_input_pkg::CODE_MIN;
        else if (code_s.valid)
            next_s.code = code_s.data;
    end

    // State register; code resets to span bottom
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s      <= '0;
            s.st   <= dac_input_pkg::RX_IDLE;
            s.code <= dac_input_pkg::CODE_MIN;
        end
        else
            s <= next_s;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_async_edge;
        amode && link_rise && s.st == dac_input_pkg::RX_RECV;
    endsequence

    a_clear_forces_min: assert property (clr |=> s.code == dac_input_pkg::CODE_MIN)
        else $error("code not at bottom during clear");
    a_span_follows_pins: assert property (##1 s.span == $past(s.rng_sync[1]))
        else $error("span does not follow range pins");
    a_start_enters_frame: assert property (amode && link_rise && s.st == dac_input_pkg::RX_IDLE && !din
        |=> s.st == dac_input_pkg::RX_RECV && s.cnt == dac_input_pkg::CNT_FIRST)
        else $error("start bit not taken");
    a_false_start_drop: assert property (s_async_edge and (s.cnt == dac_input_pkg::START_CHECK && din)
        |=> s.st == dac_input_pkg::RX_IDLE)
        else $error("high start cell not dropped");
    a_msb_sampled: assert property (s_async_edge and (s.cnt == dac_input_pkg::MSB_SAMPLE)
        |=> s.shreg[0] == $past(din) && s.cnt == $past(s.cnt) + 9'h001)
        else $error("top data bit not sampled at 24");
    a_good_stop_push: assert property (s_async_edge and (s.cnt == dac_input_pkg::STOP_SAMPLE && din)
        |=> s.word == $past(s.shreg) ##[1:20] s.push_pend)
        else $error("good frame not handed on");
    a_bad_stop_pulse: assert property (s_async_edge and (s.cnt == dac_input_pkg::STOP_SAMPLE && !din)
        |=> s.dout && s.st == dac_input_pkg::RX_IDLE && s.word == $past(s.word))
        else $error("framing error not flagged");
    a_error_pulse_ends: assert property (amode && s.dout && link_rise
        && s.st != dac_input_pkg::RX_RECV |=> !s.dout)
        else $error("error pulse longer than one link clock");
    a_latch_loads: assert property (!amode && latch_rise && !s.push_pend
        |=> s.push_pend && s.word == $past(s.shreg))
        else $error("latch did not load shift register");
    a_daisy_out: assert property (!amode && link_rise |=> s.dout == $past(s.shreg[WIDTH-1]))
        else $error("daisy output wrong");
    a_code_update: assert property (!clr && code_s.valid |=> s.code == $past(code_s.data))
        else $error("code not updated from buffer");
endmodule
`default_nettype wire

// ===== verif/host_model.sv
// Host side model driving link clock, serial data and load strobe
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic clk,
    input  wire logic data_out,
    output logic      link_clk,
    output logic      data_in,
    output logic      latch
);
    // Link clock parked low, data idle high
    initial
    begin
        link_clk = 1'b0;
        data_in  = 1'b1;
        latch    = 1'b0;
    end

    // One link period of 8 clk, low half first
    task automatic tick();
        repeat (4) @(posedge clk);
        link_clk <= 1'b1;
        repeat (4) @(posedge clk);
        link_clk <= 1'b0;
    endtask

    // Framed word, 16 link clocks a cell, then idle high
    task automatic frame(input logic [15:0] w, input logic stop_bit);
        logic [17:0] bits;
        bits = {1'b0, w, stop_bit};
        for (int k = 0; k < 288; k++)
        begin
            data_in <= bits[17 - k / 16];
            tick();
        end
        data_in <= 1'b1;
        repeat (16) tick();
    endtask

    // Three-wire shift, top bit first; records the bits passed on
    task automatic shift(input logic [15:0] w, output logic [15:0] seen);
        for (int i = 15; i >= 0; i--)
        begin
            data_in <= w[i];
            tick();
            repeat (4) @(posedge clk);
            seen[i] = data_out;
        end
        data_in <= 1'b1;
    endtask

    // Load strobe pulse well after the last link rise
    task automatic load();
        repeat (4) @(posedge clk);
        latch <= 1'b1;
        repeat (8) @(posedge clk);
        latch <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_serial_dac_loop_input_control.sv
// Self-checking bench for the serial converter input control
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD %s expected %h seen %h", what, exp, got); end end
module tb_serial_dac_loop_input_control;
    localparam int LINK_CLKS = 8; // 400 ns link period at 50 ns
    logic        clk;
    logic        rst_b;
    logic        link_clk;
    logic        data_in;
    logic        latch;
    logic        clear;
    logic [1:0]  range_sel;
    logic        async_mode;
    logic        data_out;
    logic [15:0] dac_code;
    logic [1:0]  span;
    logic [31:0] seed;
    logic [15:0] model_code;
    logic [15:0] wa;
    logic [15:0] wb;
    logic [15:0] seen;
    int          err_hi;
    int          cycles;
    int          checks;
    int          miscompares;

    serial_dac_loop_input_control dut (
        .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .data_in(data_in), .latch(latch),
        .clear(clear), .range_sel(range_sel), .async_mode(async_mode),
        .data_out(data_out), .dac_code(dac_code), .span(span));
    host_model host (
        .clk(clk), .data_out(data_out), .link_clk(link_clk), .data_in(data_in), .latch(latch));

    // Clock and error pulse width count
    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (data_out && async_mode) err_hi <= err_hi + 1;
        if (cycles == 30000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // Xorshift source of random words
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Counts and verdict
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        rst_b = 1'b0; clear = 1'b0; range_sel = 2'h0; async_mode = 1'b1;
        seed = 32'hcfce88fb; model_code = 16'h0000; err_hi = 0;
        cycles = 0; checks = 0; miscompares = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("dac_code", model_code, dac_code)
        for (int s = 0; s < 4; s++)
        begin
            range_sel <= s[1:0];
            repeat (6) @(posedge clk);
            `CHK("span", s[1:0], span)
        end
        $display("test span done");
        // Good frames, then a bad stop carrying a word unlike the held code
        for (int n = 0; n < 4; n++)
        begin
            seed = xs(seed);
            err_hi <= 0;
            host.frame((n == 3) ? ~model_code : seed[15:0], n != 3);
            if (n != 3) model_code = seed[15:0];
            `CHK("dac_code", model_code, dac_code)
            `CHK("err_pulse", (n == 3) ? LINK_CLKS : 0, err_hi)
        end
        $display("test async done");
        // Clear over every span, then released
        clear <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            range_sel <= s[1:0];
            repeat (6) @(posedge clk);
            `CHK("dac_code", 16'h0000, dac_code)
        end
        clear <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK("dac_code", 16'h0000, dac_code)
        $display("test clear done");
        // Three-wire load, daisy output, load during clear, load after clear
        async_mode <= 1'b0;
        repeat (6) @(posedge clk);
        seed = xs(seed);
        wa = seed[15:0];
        wb = seed[31:16];
        host.shift(wa, seen);
        host.load();
        `CHK("dac_code", wa, dac_code)
        host.shift(wb, seen);
        `CHK("daisy", wa, seen)
        clear <= 1'b1;
        repeat (8) @(posedge clk);
        host.load();
        `CHK("dac_code", 16'h0000, dac_code)
        clear <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("dac_code", 16'h0000, dac_code)
        host.load();
        model_code = wb;
        `CHK("dac_code", model_code, dac_code)
        $display("test three_wire done");
        // Reset in mid-run drops the loaded code to the bottom
        rst_b <= 1'b0;
        model_code = 16'h0000;
        repeat (2) @(posedge clk);
        `CHK("dac_code", model_code, dac_code)
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("dac_code", model_code, dac_code)
        $display("test reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
